// >>> acs_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module acs_adc_conversion_sequencer
    import acs_pkg::*;
#(
    parameter int NUM_INPUTS = 8,
    parameter int CONV_CYCLES = 64,
    parameter int FIFO_DEPTH = 8
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Serial link from the host
    input wire logic SCLK_I,
    input wire logic SDI_I,
    input wire logic CS_B_I,
    input wire logic FRAME_SYNC_IN_I,
    input wire logic SAMPLE_START_N_I,
    output logic SDO_O,
    // Configuration
    input wire logic [1:0] CONV_MODE_I,
    input wire logic [1:0] SWEEP_SEQ_I,
    input wire logic PIN_ROLE_EOC_I,
    input wire logic [1:0] FIFO_TRIG_I,
    input wire logic LONG_SAMPLE_I,
    input wire logic EXT_SAMPLE_I,
    // Analog front end
    input wire logic [RES_W-1:0] ADC_RESULT_I,
    // Status
    output logic EOC_INT_B_O,
    output logic [3:0] MUX_SEL_O,
    output logic SAMPLING_O,
    output logic CONVERTING_O,
    output logic [3:0] FIFO_COUNT_O
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Channel at a sweep position; four-input parts treat code 01 as 00
    function automatic logic [3:0] seq_chan(input logic [1:0] code, input logic [2:0] idx,
                                             input logic four);
        logic [2:0] ch;
        ch = 3'h0;
        case (code)
            SEQ_LINEAR: ch = four ? {1'b0, idx[1:0]} : idx;
            SEQ_EVEN: ch = four ? {1'b0, idx[1:0]} : {idx[1:0], 1'b0};
            SEQ_PAIRS: ch = four ? {1'b0, idx[2:1]} : {idx[2:1], 1'b0};
            default: ch = four ? {2'h0, idx[0]} : {1'b0, idx[0], 1'b0};
        endcase
        return {1'b0, ch};
    endfunction : seq_chan

    // Command nibble decodes as a conversion (channel or test input)
    function automatic logic is_conv(input logic [3:0] cmd);
        return (cmd <= CMD_CHAN_LAST) || (cmd >= CMD_TEST_FIRST && cmd <= CMD_TEST_LAST);
    endfunction : is_conv

    // ------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [4:0] sync1_reg; // First stage, read only by second stage
    logic [4:0] sync2_reg; // Second stage
    logic [4:0] sync3_reg; // Delayed copy for edges
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic fs_fall;
    logic start_fall;
    logic start_rise;

    // Pins are asynchronous to CLK_I; two flops before any use
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            // Idle levels: clock and data low, strobes high, so no false edge
            sync1_reg <= 5'h0E;
            sync2_reg <= 5'h0E;
            sync3_reg <= 5'h0E;
        end
        else
        begin
            sync1_reg <= {SDI_I, SAMPLE_START_N_I, FRAME_SYNC_IN_I, CS_B_I, SCLK_I};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign sclk_rise = sync2_reg[0] & ~sync3_reg[0];
    assign sclk_fall = ~sync2_reg[0] & sync3_reg[0];
    assign cs_fall = ~sync2_reg[1] & sync3_reg[1];
    // Frame sync restarts a frame while select stays low
    assign fs_fall = ~sync2_reg[2] & sync3_reg[2] & ~sync2_reg[1];
    assign start_fall = ~sync2_reg[3] & sync3_reg[3];
    assign start_rise = sync2_reg[3] & ~sync3_reg[3];

    // ------------------------------------------------------------------
    // Frame tracking and command shift
    // ------------------------------------------------------------------
    logic frame_start;
    logic [4:0] edge_cnt_reg; // Rising serial edges since frame start
    logic [2:0] cmd_reg; // First command bits
    logic [3:0] cmd_now;
    logic decode_now; // Fourth rising edge of the frame

    assign frame_start = cs_fall | fs_fall;
    // Data goes through the same two stages as the clock, so they stay aligned
    assign cmd_now = {cmd_reg, sync2_reg[4]};
    assign decode_now = sclk_rise && (edge_cnt_reg == CMD_BITS - 5'h01);

    // Edge counter saturates so a long frame cannot wrap into a second decode
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            edge_cnt_reg <= 5'h00;
            cmd_reg <= 3'h0;
        end
        else if (frame_start)
        begin
            edge_cnt_reg <= 5'h00;
        end
        else if (sclk_rise)
        begin
            if (edge_cnt_reg != EDGE_CNT_MAX)
            begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
            if (edge_cnt_reg < CMD_BITS)
            begin
                cmd_reg <= cmd_now[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    logic four_in;
    logic fifo_mode;
    logic sweep_mode;
    logic [3:0] thr;
    logic [4:0] start_edge;
    logic [2:0] seq_last;

    assign four_in = (NUM_INPUTS == 4);
    assign fifo_mode = (CONV_MODE_I != MODE_ONE_SHOT);
    assign sweep_mode = CONV_MODE_I[1];
    // Trigger level counts only in sweep modes; otherwise the queue fills up
    assign thr = !sweep_mode ? THR_FULL :
                 (FIFO_TRIG_I == TRIG_FULL) ? THR_FULL :
                 (FIFO_TRIG_I <= TRIG_HALF) ? THR_HALF : THR_QUARTER;
    assign start_edge = LONG_SAMPLE_I ? CONV_START_LONG : CONV_START_SHORT;
    assign seq_last = (SWEEP_SEQ_I == SEQ_ALT) ? SEQ_LAST_ALT : SEQ_LAST_FULL;

    // ------------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------------
    acs_state_t state_reg;
    logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_reg;
    logic [3:0] chan_reg; // Channel on the multiplexer
    logic [2:0] seq_idx_reg; // Sweep position
    logic sweep_halt_reg; // Sweep ended, waits for FIFO drain
    logic int_pend_reg; // Interrupt request outstanding
    logic conv_done;
    logic trig_ok;
    logic read_cmd;
    logic clear_fifo;
    logic [3:0] count_reg;

    assign conv_done = (state_reg == ST_CONVERT) && (conv_cnt_reg == '0);
    // A halted sweep in MODE_SWEEP ignores triggers until the FIFO is read out
    assign trig_ok = !(sweep_mode && !CONV_MODE_I[0] && sweep_halt_reg);
    assign read_cmd = decode_now && (cmd_now == CMD_READ_FIFO);
    // In repeat modes, unread data is dropped by any non-read cycle after the interrupt
    assign clear_fifo = fifo_mode && CONV_MODE_I[0] && int_pend_reg &&
                        ((decode_now && !read_cmd) || (EXT_SAMPLE_I && start_fall));

    // Sampling and conversion control
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_reg <= ST_IDLE;
            conv_cnt_reg <= '0;
            chan_reg <= 4'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // A conversion command (only arms with external sampling), or a start pin fall with external sampling in FIFO modes, starts a sample
                    if (decode_now && is_conv(cmd_now) && trig_ok)
                    begin
                        chan_reg <= sweep_mode ? seq_chan(SWEEP_SEQ_I, seq_idx_reg, four_in)
                                               : cmd_now;
                        state_reg <= EXT_SAMPLE_I ? ST_ARMED : ST_SAMPLE;
                    end
                    else if (EXT_SAMPLE_I && fifo_mode && start_fall && trig_ok)
                    begin
                        if (sweep_mode)
                        begin
                            chan_reg <= seq_chan(SWEEP_SEQ_I, seq_idx_reg, four_in);
                        end
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_ARMED:
                begin
                    // Channel chosen; the start pin opens the window
                    if (start_fall)
                    begin
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE:
                begin
                    if (EXT_SAMPLE_I ? start_rise :
                        (sclk_rise && edge_cnt_reg == start_edge - 5'h01))
                    begin
                        conv_cnt_reg <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    // Fixed internal conversion time
                    if (conv_cnt_reg == '0)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        conv_cnt_reg <= conv_cnt_reg - 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result FIFO and output buffer
    // ------------------------------------------------------------------
    logic [RES_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [2:0] rd_ptr_reg;
    logic [2:0] wr_ptr_reg;
    logic [RES_W-1:0] out_reg; // One-shot result, FIFO bypassed
    logic push;

    assign push = conv_done && fifo_mode && (count_reg < 4'(FIFO_DEPTH));

    // Clear wins over a pop; a push in the same cycle lands after the clear
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rd_ptr_reg <= 3'h0;
            wr_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
            out_reg <= '0;
        end
        else
        begin
            if (conv_done && !fifo_mode)
            begin
                out_reg <= ADC_RESULT_I;
            end
            if (clear_fifo)
            begin
                rd_ptr_reg <= 3'h0;
                wr_ptr_reg <= push ? 3'h1 : 3'h0;
                count_reg <= push ? 4'h1 : 4'h0;
            end
            else
            begin
                if (push)
                begin
                    wr_ptr_reg <= wr_ptr_reg + 3'h1;
                end
                if (read_cmd && count_reg != 4'h0)
                begin
                    rd_ptr_reg <= rd_ptr_reg + 3'h1;
                end
                count_reg <= count_reg + {3'h0, push} -
                             {3'h0, read_cmd && count_reg != 4'h0};
            end
        end
    end

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge CLK_I)
    begin
        if (push)
        begin
            fifo_mem[clear_fifo ? 3'h0 : wr_ptr_reg] <= ADC_RESULT_I;
        end
    end

    // ------------------------------------------------------------------
    // Sweep position and halt
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            seq_idx_reg <= 3'h0;
            sweep_halt_reg <= 1'b0;
        end
        else if (!sweep_mode || clear_fifo || (sweep_halt_reg && count_reg == 4'h0))
        begin
            // New sweep once the host has drained the FIFO
            seq_idx_reg <= 3'h0;
            sweep_halt_reg <= 1'b0;
        end
        else if (conv_done)
        begin
            seq_idx_reg <= (seq_idx_reg == seq_last) ? 3'h0 : seq_idx_reg + 3'h1;
            if (seq_idx_reg == seq_last || count_reg + 4'h1 >= thr)
            begin
                sweep_halt_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    logic int_set;
    logic int_clr;

    assign int_set = conv_done && (fifo_mode ? (count_reg + 4'h1 == thr) : 1'b1);
    assign int_clr = fifo_mode ? (decode_now && int_pend_reg) : frame_start;

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            int_pend_reg <= 1'b0;
        end
        else if (int_set)
        begin
            int_pend_reg <= 1'b1;
        end
        else if (int_clr)
        begin
            int_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial data output
    // ------------------------------------------------------------------
    logic [15:0] sh_reg;

    // Oldest queued result (or the one-shot result) is loaded at frame start, MSB first on falling edges
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sh_reg <= 16'h0000;
            SDO_O <= 1'b0;
        end
        else if (frame_start)
        begin
            sh_reg <= {(fifo_mode && count_reg != 4'h0) ? fifo_mem[rd_ptr_reg] : out_reg,
                       4'h0};
            SDO_O <= (fifo_mode && count_reg != 4'h0) ? fifo_mem[rd_ptr_reg][RES_W-1]
                                                       : out_reg[RES_W-1];
        end
        else if (sclk_fall && !sync2_reg[1])
        begin
            sh_reg <= {sh_reg[14:0], 1'b0};
            SDO_O <= sh_reg[14];
        end
    end

    // ------------------------------------------------------------------
    // Status outputs, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            EOC_INT_B_O <= 1'b1;
            MUX_SEL_O <= 4'h0;
            SAMPLING_O <= 1'b0;
            CONVERTING_O <= 1'b0;
            FIFO_COUNT_O <= 4'h0;
        end
        else
        begin
            // End-of-conversion role only works in one-shot mode
            EOC_INT_B_O <= (PIN_ROLE_EOC_I && !fifo_mode) ? (state_reg != ST_CONVERT)
                                                          : !int_pend_reg;
            MUX_SEL_O <= chan_reg;
            SAMPLING_O <= (state_reg == ST_SAMPLE);
            CONVERTING_O <= (state_reg == ST_CONVERT);
            FIFO_COUNT_O <= count_reg;
        end
    end

endmodule : acs_adc_conversion_sequencer

// >>> acs_checker_assertions.sv
`timescale 1ns/1ps
module acs_checker
    import acs_pkg::*;
#(
    parameter int CONV_CYCLES = 64
)
(
    // Clock, reset and configuration
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic SAMPLE_START_N_I,
    input wire logic [1:0] CONV_MODE_I,
    input wire logic [1:0] FIFO_TRIG_I,
    input wire logic PIN_ROLE_EOC_I,
    input wire logic EXT_SAMPLE_I,
    // Status
    input wire logic EOC_INT_B_O,
    input wire logic SAMPLING_O,
    input wire logic CONVERTING_O,
    input wire logic [3:0] FIFO_COUNT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // One-shot mode decoded once for several checks
    wire logic one_shot = CONV_MODE_I == MODE_ONE_SHOT;
    phase_excl_a: assert property (!(SAMPLING_O && CONVERTING_O))
        else $error("sampling and converting together");
    // Cycles spent converting; a counter keeps long conversions cheap to check
    logic [15:0] conv_run;
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            conv_run <= 16'h0000;
        else
            conv_run <= CONVERTING_O ? conv_run + 16'h0001 : 16'h0000;
    end
    conv_len_a: assert property ($fell(CONVERTING_O) |->
        conv_run == 16'(CONV_CYCLES)) else $error("conversion length wrong");
    eoc_role_a: assert property (one_shot && PIN_ROLE_EOC_I && CONVERTING_O &&
        $past(CONVERTING_O) |-> !EOC_INT_B_O) else $error("end flag missing");
    int_role_a: assert property (one_shot && !PIN_ROLE_EOC_I &&
        $fell(CONVERTING_O) |-> ##[0:2] !EOC_INT_B_O) else $error("interrupt missing");
    fifo_bypass_a: assert property (one_shot |-> FIFO_COUNT_O == 4'h0)
        else $error("one-shot used the queue");
    ext_fall_a: assert property (EXT_SAMPLE_I && CONV_MODE_I == MODE_REPEAT &&
        FIFO_COUNT_O == 4'h0 && !CONVERTING_O && $fell(SAMPLE_START_N_I)
        |-> ##[1:6] SAMPLING_O) else $error("start fall ignored");
    ext_rise_a: assert property (EXT_SAMPLE_I && SAMPLING_O &&
        $rose(SAMPLE_START_N_I) |-> ##[1:6] CONVERTING_O) else $error("start rise ignored");
    thr_int_a: assert property (CONV_MODE_I == MODE_SWEEP && FIFO_TRIG_I == 2'h3 &&
        $rose(FIFO_COUNT_O == THR_QUARTER) |-> ##[0:2] !EOC_INT_B_O) else $error("no irq");
    sweep_stop_a: assert property (CONV_MODE_I == MODE_SWEEP && FIFO_TRIG_I == 2'h3
        |-> FIFO_COUNT_O <= THR_QUARTER) else $error("sweep ran past threshold");
    conv_seen_c: cover property ($rose(CONVERTING_O));
    irq_seen_c: cover property ($fell(EOC_INT_B_O));
    full_seen_c: cover property (FIFO_COUNT_O == THR_FULL);
endmodule : acs_checker

bind acs_adc_conversion_sequencer acs_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .SAMPLE_START_N_I(SAMPLE_START_N_I), .CONV_MODE_I(CONV_MODE_I),
    .FIFO_TRIG_I(FIFO_TRIG_I), .PIN_ROLE_EOC_I(PIN_ROLE_EOC_I), .EXT_SAMPLE_I(EXT_SAMPLE_I),
    .EOC_INT_B_O(EOC_INT_B_O), .SAMPLING_O(SAMPLING_O), .CONVERTING_O(CONVERTING_O),
    .FIFO_COUNT_O(FIFO_COUNT_O));

// >>> acs_host_model.sv
`timescale 1ns/1ps
module acs_host_model (
    // Pacing clock and observed pins
    input wire logic clk_i,
    input wire logic sdo_i,
    input wire logic conv_i,
    // Serial pins towards the converter
    output logic sclk_o,
    output logic sdi_o,
    output logic cs_b_o,
    output logic fs_o
);
    // Serial clock stands low between frames
    initial
    begin
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        cs_b_o = 1'b1;
        fs_o = 1'b1;
    end

    // Wait n edges, then step just past the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : hold

    // One frame: command nibble, filler bits, SDO captured before each of the first 16 rises
    task automatic frame(input logic [3:0] cmd, input bit fs, input int nclk,
                         output logic [15:0] word, output int conv_at);
        word = 16'h0000;
        conv_at = 0;
        if (fs)
        begin
            // Select stays low; each sync pulse is a new trigger
            if (cs_b_o) begin cs_b_o = 1'b0; hold(8); end
            fs_o = 1'b0;
        end
        else
        begin
            cs_b_o = 1'b1;
            hold(8);
            cs_b_o = 1'b0;
        end
        hold(8);
        fs_o = 1'b1;
        for (int i = 0; i < nclk; i++)
        begin
            // Filler toggles so a late read of SDI never sees a stale bit
            sdi_o = (i < 4) ? cmd[3 - i] : ~sdi_o;
            if (conv_at == 0 && conv_i) conv_at = i;
            hold(4);
            // SDO has settled after the previous fall by now
            if (i < 16) word = {word[14:0], sdo_i};
            sclk_o = 1'b1;
            hold(4);
            sclk_o = 1'b0;
        end
        hold(8);
    endtask : frame
endmodule : acs_host_model

// >>> acs_pkg.sv
package acs_pkg;

    // ------------------------------------------------------------------
    // Conversion modes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_SWEEP = 2'h2;
    localparam logic [1:0] MODE_REP_SWEEP = 2'h3;

    // ------------------------------------------------------------------
    // Command nibble codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_CHAN_LAST = 4'h7;
    localparam logic [3:0] CMD_TEST_FIRST = 4'hB;
    localparam logic [3:0] CMD_TEST_LAST = 4'hD;
    localparam logic [3:0] CMD_READ_FIFO = 4'hE;

    // ------------------------------------------------------------------
    // Serial timing, counted in serial clock edges
    // ------------------------------------------------------------------
    localparam logic [4:0] CMD_BITS = 5'h04;
    localparam logic [4:0] SHORT_SAMPLE_CLKS = 5'h0C;
    localparam logic [4:0] LONG_SAMPLE_CLKS = 5'h18;
    localparam logic [4:0] CONV_START_SHORT = CMD_BITS + SHORT_SAMPLE_CLKS;
    localparam logic [4:0] CONV_START_LONG = CMD_BITS + LONG_SAMPLE_CLKS;
    localparam logic [4:0] EDGE_CNT_MAX = 5'h1F;

    // ------------------------------------------------------------------
    // Result and FIFO thresholds (entries held when the interrupt fires)
    // ------------------------------------------------------------------
    localparam int RES_W = 12;
    localparam logic [1:0] TRIG_FULL = 2'h0;
    localparam logic [1:0] TRIG_HALF = 2'h2;
    localparam logic [3:0] THR_FULL = 4'h8;
    localparam logic [3:0] THR_HALF = 4'h6;
    localparam logic [3:0] THR_QUARTER = 4'h4;

    // ------------------------------------------------------------------
    // Sweep sequence codes and lengths
    // ------------------------------------------------------------------
    localparam logic [1:0] SEQ_LINEAR = 2'h0;
    localparam logic [1:0] SEQ_EVEN = 2'h1;
    localparam logic [1:0] SEQ_PAIRS = 2'h2;
    localparam logic [1:0] SEQ_ALT = 2'h3;
    localparam logic [2:0] SEQ_LAST_FULL = 3'h7;
    localparam logic [2:0] SEQ_LAST_ALT = 3'h5;

    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SAMPLE, ST_CONVERT} acs_state_t;

endpackage : acs_pkg

// >>> tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_adc_conversion_sequencer
    import acs_pkg::*;
();
    // Stimulus, observed outputs and bookkeeping
    logic clk = 1'b0, rst_b = 1'b0, start_n = 1'b1, role = 1'b0, long_s = 1'b0, ext = 1'b0;
    logic [1:0] mode = 2'h0, seq = 2'h0, trig = 2'h0;
    logic [11:0] adc = 12'h000, last = 12'h000;
    wire sclk, sdi, cs_b, fs, sdo, eoc_b, samp, conv;
    wire [3:0] mux, cnt;
    int errors = 0, n_checks = 0, cyc = 0, conv_at, thr;
    logic [15:0] word;
    logic [3:0] exp_q[$];
    logic [11:0] res_q[$];
    logic conv_d = 1'b0;
    logic [3:0] want_ch;

    always #10 clk = ~clk;

    acs_adc_conversion_sequencer #(.CONV_CYCLES(8)) DUT (.CLK_I(clk), .RST_B_I(rst_b),
        .SCLK_I(sclk), .SDI_I(sdi), .CS_B_I(cs_b), .FRAME_SYNC_IN_I(fs),
        .SAMPLE_START_N_I(start_n), .SDO_O(sdo), .CONV_MODE_I(mode), .SWEEP_SEQ_I(seq),
        .PIN_ROLE_EOC_I(role), .FIFO_TRIG_I(trig), .LONG_SAMPLE_I(long_s),
        .EXT_SAMPLE_I(ext), .ADC_RESULT_I(adc), .EOC_INT_B_O(eoc_b), .MUX_SEL_O(mux),
        .SAMPLING_O(samp), .CONVERTING_O(conv), .FIFO_COUNT_O(cnt));
    acs_host_model host (.clk_i(clk), .sdo_i(sdo), .conv_i(conv), .sclk_o(sclk),
        .sdi_o(sdi), .cs_b_o(cs_b), .fs_o(fs));

    // Verdict and end of run
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    // Hang guard, well above the expected length of the run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000) begin errors++; final_report(); end
    end

    // Each conversion start takes the oldest expected channel
    always @(posedge clk)
    begin
        conv_d <= conv;
        if (rst_b && conv && !conv_d)
        begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0)
            begin
                want_ch = exp_q.pop_front();
                `CHK(mux, want_ch)
            end
        end
    end

    // Sweep order table for the eight-input build
    function automatic logic [3:0] ch(input int s, input int i);
        case (s)
            0: return 4'(i);
            1: return 4'((2 * i) % 8);
            2: return 4'((i / 2) * 2);
            default: return 4'((i % 2) * 2);
        endcase
    endfunction : ch

    // One trigger frame; notes the expected channel and conversion point
    task automatic go(input logic [3:0] cmd, input logic [3:0] exp_ch, input bit cv,
                      input bit fsy);
        adc = 12'($urandom);
        if (cv) begin exp_q.push_back(exp_ch); res_q.push_back(adc); end
        host.frame(cmd, fsy, 30, word, conv_at);
        `CHK(conv_at, cv ? (long_s ? 28 : 16) : 0)
    endtask : go

    initial
    begin
        void'($urandom(32'h89a69d5a));
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        // ----------------------------------------------------------------
        // One-shot: every conversion code plus codes 8 and E, both lengths and pin roles
        // ----------------------------------------------------------------
        for (int i = 0; i < 13; i++)
        begin
            long_s = i[0];
            role = i[1];
            go(4'(i < 8 ? i : i < 11 ? i + 3 : i == 11 ? 8 : 14), 4'(i < 8 ? i : i + 3),
               i < 11, 0);
            if (i > 0) `CHK(word, {last, 4'h0})
            if (i < 11) last = adc;
        end
        `CHK(cnt, 4'h0)
        res_q.delete();
        // ----------------------------------------------------------------
        // Sweep: each order and trigger level, sync-pulse triggers only
        // ----------------------------------------------------------------
        mode = MODE_SWEEP;
        long_s = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            seq = 2'(s);
            trig = 2'(s);
            thr = s == 0 ? 8 : s == 3 ? 4 : 6;
            for (int i = 0; i < thr; i++) go(4'h0, ch(s, i), 1, 1);
            `CHK(cnt, 4'(thr))
            `CHK(eoc_b, 1'b0)
            go(4'h0, 4'h0, 0, 1);
            for (int i = 0; i < thr; i++)
            begin
                go(CMD_READ_FIFO, 4'h0, 0, 1);
                last = res_q.pop_front();
                `CHK(word, {last, 4'h0})
            end
            `CHK(cnt, 4'h0)
        end
        // ----------------------------------------------------------------
        // Repeat: pin-started first sample, threshold ignored, overrun
        // ----------------------------------------------------------------
        mode = MODE_REPEAT;
        long_s = 1'b1;
        ext = 1'b1;
        go(4'h3, 4'h3, 0, 0);
        exp_q.push_back(4'h3);
        start_n = 1'b0;
        host.hold(50);
        start_n = 1'b1;
        host.hold(30);
        ext = 1'b0;
        for (int i = 0; i < 7; i++) go(4'h3, 4'h3, 1, 0);
        `CHK(cnt, THR_FULL)
        `CHK(eoc_b, 1'b0)
        go(4'h3, 4'h3, 1, 0);
        `CHK(cnt, 4'h1)
        // Repeat sweep: quarter threshold interrupts, an unread queue is dropped
        mode = MODE_REP_SWEEP;
        for (int i = 0; i < 3; i++) go(4'h0, ch(3, i), 1, 0);
        `CHK(cnt, THR_QUARTER)
        `CHK(eoc_b, 1'b0)
        go(4'h0, ch(3, 3), 1, 0);
        `CHK(cnt, 4'h1)
        host.hold(40);
        `CHK(exp_q.size(), 0)
        final_report();
    end
endmodule : tb_adc_conversion_sequencer
